// ===== hdl/dpr_rom_top.sv
// Purpose: AHB-Lite slave presenting the discoverable parameter table
// Assumes: Single word transfers, one master, same clock
// Notes:   Zero wait states; writes to the table are dropped and counted

`timescale 1ns/1ns
`default_nettype none

module dpr_rom_top
  import dpr_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // AHB-Lite address phase
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic        hready_in,
  // AHB-Lite data phase
  input  wire logic [31:0] hwdata_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out
);

  // ----------------------------------------------------------------
  // Address phase decode
  // ----------------------------------------------------------------
  logic             take;
  logic [IDX_W-1:0] idx;
  logic             in_pad;
  logic             in_jb;
  logic             in_sfdp;
  logic             in_ctrl;
  logic             in_stat;
  logic             in_table;
  logic [31:0]      ctrl;
  logic [15:0]      dropped;
  logic [IDX_W-1:0] last_rd;

  // Only whole words travel; hsize is not checked
  assign take = hsel_in && hready_in && htrans_in[1];
  assign idx  = haddr_in[IDX_W+1:2];

  assign in_pad  = (idx >= IDX_PAD) && (idx < IDX_JB);
  assign in_jb   = (idx >= IDX_JB) && (idx < IDX_JB_NEXT);
  assign in_sfdp = ctrl[CTRL_SFDP_BIT] && (idx >= IDX_SFDP)
                   && (idx < IDX_SFDP_END);
  assign in_ctrl = (idx == IDX_CTRL);
  assign in_stat = (idx == IDX_STAT);
  assign in_table = in_pad || in_jb || in_sfdp;

  // ----------------------------------------------------------------
  // Table lookup
  // ----------------------------------------------------------------
  logic [7:0] pad_ofs;
  logic [7:0] pad_byte;
  logic [7:0] jb_rel;
  logic [7:0] jb_ofs;
  logic [7:0] jb_byte;
  logic [7:0] tbl_byte;

  assign pad_ofs = 8'(idx - IDX_PAD);
  assign jb_rel  = 8'(idx - IDX_JB);

  // One content decoder serves both the parameter and its mirror
  always_comb begin
    if (in_sfdp) begin
      jb_ofs = 8'(idx - IDX_SFDP);
    end else begin
      jb_ofs = jb_rel - HDR_LEN;
    end
  end

  dpr_pad_param #(
    .LEN (PAD_LEN)
  ) u_pad (
    .ofs_in   (pad_ofs),
    .byte_out (pad_byte)
  );

  dpr_jedec_basic u_jb (
    .ofs_in   (jb_ofs),
    .byte_out (jb_byte)
  );

  always_comb begin
    tbl_byte = 8'h00;
    if (in_pad) begin
      tbl_byte = pad_byte;
    end else if (in_sfdp) begin
      tbl_byte = jb_byte;
    end else if (in_jb) begin
      if (jb_rel == 8'h00) begin
        tbl_byte = JB_ID;
      end else if (jb_rel == 8'h01) begin
        tbl_byte = JB_LEN;
      end else begin
        tbl_byte = jb_byte;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data, captured at the address phase
  // ----------------------------------------------------------------
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (in_table) begin
      next_rdata = {24'h00_0000, tbl_byte};
    end else if (in_ctrl) begin
      next_rdata = ctrl;
    end else if (in_stat) begin
      next_rdata = {2'h0, last_rd, dropped};
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      hrdata_out <= 32'h0000_0000;
    end else if (take && !hwrite_in) begin
      hrdata_out <= next_rdata;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      last_rd <= 14'h0000;
    end else if (take && !hwrite_in && in_table) begin
      last_rd <= idx;
    end
  end

  // Slave never stalls and never errors
  assign hreadyout_out = 1'b1;
  assign hresp_out     = HRESP_OKAY;

  // ----------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------
  logic wr_ctrl;
  logic wr_table;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ctrl  <= 1'b0;
      wr_table <= 1'b0;
    end else if (hready_in) begin
      wr_ctrl  <= take && hwrite_in && in_ctrl;
      wr_table <= take && hwrite_in && in_table;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl <= {31'h0000_0000, hwdata_in[CTRL_SFDP_BIT]};
    end
  end

  // Table is constant; a write only bumps a saturating counter
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dropped <= 16'h0000;
    end else if (wr_table && (dropped != 16'hffff)) begin
      dropped <= dropped + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  logic rd_take;
  assign rd_take = take && !hwrite_in;

  a_pad_id: assert property (
    rd_take && idx == IDX_PAD |=> hrdata_out == {24'h0, PAD_ID})
    else $error("padding id wrong");

  a_pad_fill: assert property (
    rd_take && idx > IDX_PAD + 14'h0001 && idx < IDX_JB
    |=> hrdata_out == {24'h0, PAD_FILL})
    else $error("padding fill wrong");

  a_pad_len: assert property (
    rd_take && idx == IDX_PAD + 14'h0001 |=> hrdata_out == 32'h0000_000f)
    else $error("padding length wrong");

  // Length byte at one, plus its value, plus one lands on the next header
  a_next_param: assert property (
    rd_take && idx == IDX_PAD + 14'h0011 |=> hrdata_out == {24'h0, JB_ID})
    else $error("next parameter position wrong");

  a_jb_header: assert property (
    rd_take && idx == IDX_JB + 14'h0001 |=> hrdata_out == 32'h80)
    else $error("jedec length wrong");

  a_sfdp_mirror: assert property (
    rd_take && idx == IDX_SFDP && ctrl[0]
    |=> hrdata_out == 32'he7)
    else $error("sfdp mirror wrong");

  // ----------------------------------------------------------------
  // Basic parameter bytes, one check per byte, middle two density bytes unchecked
  // ----------------------------------------------------------------
  a_dw1_low: assert property (
    rd_take && idx == IDX_JB + 14'h0002 |=> hrdata_out == 32'he7)
    else $error("dword one low byte wrong");

  a_dw1_opcode: assert property (
    rd_take && idx == IDX_JB + 14'h0003 |=> hrdata_out == 32'hff)
    else $error("dword one erase opcode wrong");

  a_dw1_bytes: assert property (
    rd_take && idx == IDX_JB + 14'h0004 |=> hrdata_out == 32'hf3)
    else $error("dword one byte two wrong");

  a_dw1_top: assert property (
    rd_take && idx == IDX_JB + 14'h0005 |=> hrdata_out == 32'hff)
    else $error("dword one top byte wrong");

  a_density_low: assert property (
    rd_take && idx == IDX_JB + 14'h0006 |=> hrdata_out == 32'hff)
    else $error("density low byte wrong");

  a_density_top: assert property (
    rd_take && idx == IDX_JB + 14'h0009 |=> hrdata_out == 32'h07)
    else $error("density top byte wrong");

  a_dw3_qio: assert property (
    rd_take && idx == IDX_JB + 14'h000a |=> hrdata_out == 32'h44)
    else $error("quad io cycles wrong");

  a_dw3_quad: assert property (
    rd_take && idx == IDX_JB + 14'h000b |=> hrdata_out == 32'heb)
    else $error("dword three wrong");

  a_dw3_qo: assert property (
    rd_take && idx == IDX_JB + 14'h000c |=> hrdata_out == 32'h08)
    else $error("quad output cycles wrong");

  a_dw3_qo_op: assert property (
    rd_take && idx == IDX_JB + 14'h000d |=> hrdata_out == 32'h6b)
    else $error("quad output opcode wrong");

  a_table_fixed: assert property (
    wr_table |=> $stable(ctrl) && dropped != $past(dropped)
    || $past(dropped) == 16'hffff)
    else $error("table write handled wrong");

  a_bus_okay: assert property (
    hreadyout_out && hresp_out == HRESP_OKAY)
    else $error("slave stalled or errored");

  // ----------------------------------------------------------------
  // Bus contract and control
  // ----------------------------------------------------------------
  // Mirror switched off must read as unmapped space
  a_mirror_off: assert property (
    rd_take && !ctrl[CTRL_SFDP_BIT] && idx >= IDX_SFDP
    && idx < IDX_SFDP_END |=> hrdata_out == 32'h0000_0000)
    else $error("mirror read while disabled");

  // Read data stands until the next read is taken
  a_rdata_hold: assert property (
    !rd_take |=> $stable(hrdata_out))
    else $error("read data moved without a read");

  a_upper_zero: assert property (
    rd_take && in_table |=> hrdata_out[31:8] == 24'h00_0000)
    else $error("table byte not alone in word");

  a_ctrl_write: assert property (
    wr_ctrl |=> ctrl == {31'h0, $past(hwdata_in[CTRL_SFDP_BIT])})
    else $error("control write not applied");

  a_stat_last: assert property (
    rd_take && in_table |=> last_rd == $past(idx))
    else $error("last read index not kept");

  c_pad_read: cover property (rd_take && in_pad ##1 1'b1);
  c_sfdp_read: cover property (rd_take && in_sfdp ##1 1'b1);
  c_table_write: cover property (wr_table);
  c_ctrl_off: cover property (wr_ctrl && !hwdata_in[0]);
  c_mirror_off: cover property (rd_take && !ctrl[0] && idx == IDX_SFDP);

endmodule

`default_nettype wire

// ===== hdl/dpr_pkg.sv
// Purpose: Constants for the discoverable parameter table
// Assumes: AHB-Lite word access, one table byte per word
// Notes:   Table bytes sit in the low byte, upper bits read zero
//
// How it works
// - Padding parameter opens with F0h; every byte past its length is FFh.
// - Byte two holds following count; next parameter sits at pos+len+1.
// - Padding may repeat with other lengths to reserve or align space.
// - JEDEC parameter block opens with A5h then length byte 80h.
// - JEDEC content starts at byte three, mirrored from SFDP address 1120h.
// - First dword low byte reads E7h: unused, zero, big buffer, no 4K.
// - First dword byte two reads F3h: quad and dual reads, 3/4 addr bytes.
// - First dword byte one and top byte read FFh.
// - Second dword holds density 07FFFFFFh, low byte first.
// - Third dword low byte 44h, then quad I/O read opcode EBh.
// - Third dword byte two 08h, then quad output read opcode 6Bh.

package dpr_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int IDX_W  = 14;

  // ----------------------------------------------------------------
  // Parameter headers and fill
  // ----------------------------------------------------------------
  localparam logic [7:0] PAD_ID   = 8'hf0;
  localparam logic [7:0] PAD_LEN  = 8'h0f;
  localparam logic [7:0] PAD_FILL = 8'hff;
  localparam logic [7:0] JB_ID    = 8'ha5;
  localparam logic [7:0] JB_LEN   = 8'h80;
  localparam logic [7:0] HDR_LEN  = 8'h02;
  localparam logic [7:0] BLANK    = 8'hff;
  localparam logic [7:0] JB_KNOWN = 8'h0c;

  // ----------------------------------------------------------------
  // Word indices of the table, byte address is four times these
  // ----------------------------------------------------------------
  localparam logic [13:0] IDX_PAD  = 14'h0000;
  localparam logic [13:0] IDX_JB   = IDX_PAD + {6'h00, PAD_LEN}
                                     + {6'h00, HDR_LEN};
  localparam logic [13:0] IDX_JB_NEXT = IDX_JB + {6'h00, JB_LEN}
                                        + {6'h00, HDR_LEN};
  localparam logic [13:0] IDX_SFDP = 14'h1120;
  localparam logic [13:0] IDX_SFDP_END = IDX_SFDP + {6'h00, JB_LEN};
  localparam logic [13:0] IDX_CTRL = 14'h2000;
  localparam logic [13:0] IDX_STAT = 14'h2001;

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_RST      = 32'h0000_0001;
  localparam int          CTRL_SFDP_BIT = 0;

  // ----------------------------------------------------------------
  // Basic flash parameter fields
  // ----------------------------------------------------------------
  localparam logic [2:0] DW1_UNUSED  = 3'h7;
  localparam logic [1:0] DW1_SR_WR   = 2'h0;
  localparam logic       DW1_BIG_BUF = 1'h1;
  localparam logic [1:0] DW1_NO_4K   = 2'h3;
  localparam logic [7:0] DW1_OP_4K   = 8'hff;
  localparam logic       DW1_UNUSED1 = 1'h1;
  localparam logic       DW1_QO_RD   = 1'h1;
  localparam logic       DW1_QIO_RD  = 1'h1;
  localparam logic       DW1_DIO_RD  = 1'h1;
  localparam logic       DW1_DDR     = 1'h0;
  localparam logic [1:0] DW1_ADDR_B  = 2'h1;
  localparam logic       DW1_DO_RD   = 1'h1;
  localparam logic [7:0] DW1_TOP     = 8'hff;
  localparam logic [31:0] DW2_DENSITY = 32'h07ff_ffff;
  localparam logic [2:0] DW3_QIO_MODE  = 3'h2;
  localparam logic [4:0] DW3_QIO_DUMMY = 5'h04;
  localparam logic [7:0] DW3_QIO_OP    = 8'heb;
  localparam logic [2:0] DW3_QO_MODE   = 3'h0;
  localparam logic [4:0] DW3_QO_DUMMY  = 5'h08;
  localparam logic [7:0] DW3_QO_OP     = 8'h6b;

  localparam logic [31:0] JB_DW1 = {DW1_TOP,
    DW1_UNUSED1, DW1_QO_RD, DW1_QIO_RD, DW1_DIO_RD, DW1_DDR, DW1_ADDR_B,
    DW1_DO_RD, DW1_OP_4K, DW1_UNUSED, DW1_SR_WR, DW1_BIG_BUF, DW1_NO_4K};
  localparam logic [31:0] JB_DW3 = {DW3_QO_OP, DW3_QO_MODE, DW3_QO_DUMMY,
    DW3_QIO_OP, DW3_QIO_MODE, DW3_QIO_DUMMY};

  // ----------------------------------------------------------------
  // AHB encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

endpackage

// ===== hdl/dpr_pad_param.sv
// Purpose: One padding parameter, byte by relative offset
// Assumes: Caller decodes the parameter's range
// Notes:   Length is a parameter so several pads may differ

`timescale 1ns/1ns
`default_nettype none

module dpr_pad_param
  import dpr_pkg::*;
#(
  parameter logic [7:0] LEN = PAD_LEN
) (
  // Offset within the parameter
  input  wire logic [7:0] ofs_in,
  // Byte at that offset
  output logic      [7:0] byte_out
);

  always_comb begin
    unique case (ofs_in)
      8'h00:   byte_out = PAD_ID;
      8'h01:   byte_out = LEN;
      default: byte_out = PAD_FILL;
    endcase
  end

endmodule

`default_nettype wire

// ===== hdl/dpr_jedec_basic.sv
// Purpose: Basic flash parameter content, byte by content offset
// Assumes: Offset zero is the first content byte
// Notes:   Dwords are little endian; unmodelled bytes read FFh

`timescale 1ns/1ns
`default_nettype none

module dpr_jedec_basic
  import dpr_pkg::*;
(
  // Offset within the content
  input  wire logic [7:0] ofs_in,
  // Byte at that offset
  output logic      [7:0] byte_out
);

  logic [31:0] dword;

  always_comb begin
    unique case (ofs_in[3:2])
      2'h0:    dword = JB_DW1;
      2'h1:    dword = DW2_DENSITY;
      2'h2:    dword = JB_DW3;
      2'h3:    dword = {4{BLANK}};
    endcase
  end

  // Least significant byte first
  always_comb begin
    if (ofs_in < JB_KNOWN) begin
      byte_out = dword[{ofs_in[1:0], 3'h0} +: 8];
    end else begin
      byte_out = BLANK;
    end
  end

endmodule

`default_nettype wire

// ===== testbench/dpr_host_model.sv
// Purpose: Host side bus master that reads the parameter table
// Assumes: Single word transfers, one slave, hready from that slave
// Notes:   Data bus shows the inverse of the last word once released

`timescale 1ns/1ns
`default_nettype none

module dpr_host_model
  import dpr_pkg::*;
(
  // Clock
  input  wire logic        clk_in,
  // Address phase
  output logic             hsel_out,
  output logic      [31:0] haddr_out,
  output logic      [1:0]  htrans_out,
  output logic             hwrite_out,
  output logic      [2:0]  hsize_out,
  // Data phase
  output logic      [31:0] hwdata_out,
  input  wire logic [31:0] hrdata_in,
  input  wire logic        hready_in
);
  initial begin
    hsel_out   = 1'b0;
    haddr_out  = 32'h0000_0000;
    htrans_out = 2'h0;
    hwrite_out = 1'b0;
    hsize_out  = 3'h2;
    hwdata_out = 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // One transfer; waits on hready with no assumed latency
  // ----------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [31:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_in);
    hsel_out   <= 1'b1;
    haddr_out  <= a;
    htrans_out <= HTRANS_NONSEQ;
    hwrite_out <= wr;
    hsize_out  <= 3'h2;
    do @(posedge clk_in); while (hready_in !== 1'b1);
    hsel_out   <= 1'b0;
    htrans_out <= 2'h0;
    haddr_out  <= ~a;
    hwdata_out <= wd;
    do @(posedge clk_in); while (hready_in !== 1'b1);
    rd = hrdata_in;
    // Released bus must not keep the old word
    hwdata_out <= ~wd;
  endtask
endmodule

`default_nettype wire

// ===== testbench/tb_discoverable_param_rom.sv
// Purpose: Self-checking bench for the parameter table slave
// Assumes: Zero wait slave, one table byte per word
// Notes:   Walks the table as a host would, by length bytes

`timescale 1ns/1ns
`default_nettype none

module tb_discoverable_param_rom
  import dpr_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic [31:0] d;
  logic [13:0] nxt;
  logic [7:0]  jb [12];
  int          fails = 0;
  int          check_count = 0;
  int          cyc = 0;

  always #2 clk_in = ~clk_in;

  dpr_rom_top i_dpr_rom_top (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .hsel_in       (hsel),
    .haddr_in      (haddr),
    .htrans_in     (htrans),
    .hwrite_in     (hwrite),
    .hsize_in      (hsize),
    .hready_in     (hready),
    .hwdata_in     (hwdata),
    .hrdata_out    (hrdata),
    .hreadyout_out (hready),
    .hresp_out     (hresp)
  );

  dpr_host_model i_dpr_host_model (
    .clk_in     (clk_in),
    .hsel_out   (hsel),
    .haddr_out  (haddr),
    .htrans_out (htrans),
    .hwrite_out (hwrite),
    .hsize_out  (hsize),
    .hwdata_out (hwdata),
    .hrdata_in  (hrdata),
    .hready_in  (hready)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    if (fails == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic logic [31:0] ba(input logic [13:0] i);
    return {16'h0000, i, 2'b00};
  endfunction

  task automatic rc(input logic [13:0] i, input logic [31:0] e);
    logic [31:0] r;
    i_dpr_host_model.xfer(1'b0, ba(i), 32'h0000_0000, r);
    check(r, e);
  endtask

  task automatic wr(input logic [13:0] i, input logic [31:0] v);
    logic [31:0] r;
    i_dpr_host_model.xfer(1'b1, ba(i), v, r);
  endtask

  // Hang guard, some 64 transfers of three cycles each expected
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    jb = '{8'he7, 8'hff, 8'hf3, 8'hff, 8'hff, 8'hff, 8'hff, 8'h07,
           8'h44, 8'heb, 8'h08, 8'h6b};
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    rc(IDX_STAT, 32'h0000_0000);
    rc(IDX_CTRL, CTRL_RST);
    rc(14'h0000, 32'h0000_00f0);
    i_dpr_host_model.xfer(1'b0, ba(14'h0001), 32'h0000_0000, d);
    check(d, 32'h0000_000f);
    // Next parameter found as a host would, from the length byte
    nxt = 14'h0001 + {6'h00, d[7:0]} + 14'h0001;
    for (int k = 2; k < nxt && k < 64; k++)
      rc(k[13:0], 32'h0000_00ff);
    rc(nxt, 32'h0000_00a5);
    rc(nxt + 14'h0001, 32'h0000_0080);
    for (int k = 0; k < 12; k++)
      rc(14'h0013 + k[13:0], {24'h0, jb[k]});
    rc(14'h001f, 32'h0000_00ff);
    for (int k = 0; k < 12; k++)
      rc(14'h1120 + k[13:0], {24'h0, jb[k]});
    // Writes aimed at the table, the mirror among them
    wr(14'h0000, 32'h0000_0000);
    wr(14'h1120, 32'h0000_0000);
    wr(14'h0013, 32'h0000_0000);
    rc(14'h0000, 32'h0000_00f0);
    rc(14'h1120, 32'h0000_00e7);
    rc(14'h0013, 32'h0000_00e7);
    rc(IDX_STAT, {2'b00, 14'h0013, 16'h0003});
    // Unmapped place reads zero and ignores writes
    wr(14'h3000, 32'hffff_ffff);
    rc(14'h3000, 32'h0000_0000);
    wr(IDX_CTRL, 32'h0000_0000);
    rc(IDX_CTRL, 32'h0000_0000);
    rc(14'h1120, 32'h0000_0000);
    // Reset in mid-run clears the drop counter and rearms the mirror
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    rc(IDX_STAT, 32'h0000_0000);
    rc(IDX_CTRL, CTRL_RST);
    rc(14'h1120, 32'h0000_00e7);
    // Only the enable bit of the control word is kept
    wr(IDX_CTRL, 32'hffff_ffff);
    rc(IDX_CTRL, 32'h0000_0001);
    rc(14'h1128, 32'h0000_0044);
    check({31'h0, hresp}, {31'h0, HRESP_OKAY});
    test_done();
  end
endmodule

`default_nettype wire
